//--- bench/dei_cpu_model.sv
/*
  Controller CPU model: an AXI4-Lite master whose tasks the bench calls,
  plus the reader's edge flag consistency test.
  Assumes it shares aclk with the slave and is called just after an edge.
*/
`timescale 1ns/10ps
`default_nettype none
module dei_cpu_model (
  input wire logic aclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // ==========================================================
  // Idle master
  initial begin
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
  end

  // ==========================================================
  // Transfers wait for the answer however long; the bench watchdog ends a hang
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    // Fresh edge first so no signal is assigned twice in one step
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (n == 0) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        n = 1;
      end
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    d = 32'hdeadbeef;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (n == 0) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        n = 1;
      end
    end
  endtask : rd

  function automatic logic [15:0] consistent(input logic [15:0] first,
    input logic [15:0] second);
    return first & ~second;
  endfunction : consistent
endmodule : dei_cpu_model
`default_nettype wire

//--- bench/dio_edge_interrupt_diagnostics_bench.sv
/*
  Self-checking bench of the edge interrupt block.
  Assumes the design files compiled first and the CPU model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
module dio_edge_interrupt_diagnostics_bench;
  logic aclk;
  logic aresetn;
  logic [11:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic [15:0] din_pin;
  logic aux_missing_pin;
  logic [15:0] dout;
  logic irq;
  int n_errors;
  int cmp_count;
  int cyc;
  int t0;
  logic [31:0] rv;
  logic [1:0] rs;
  logic [15:0] ts1;

  dei_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .din_pin,
    .aux_missing_pin, .dout, .irq);
  dei_cpu_model u_cpu (.aclk, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // ==========================================================
  // Clock, cycle count, watchdog
  initial aclk = 1'h0;
  always #25 aclk = ~aclk;
  initial cyc = 0;
  always @(posedge aclk) cyc <= cyc + 1;
  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    summarize();
  end

  // ==========================================================
  // Shared tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task w(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    u_cpu.wr(a, d, 4'hf, rs);
    chk("bresp", {30'h0, er}, {30'h0, rs});
  endtask : w

  task r(input logic [11:0] a, input logic [1:0] er);
    u_cpu.rd(a, rv, rs);
    chk("rresp", {30'h0, er}, {30'h0, rs});
  endtask : r

  task pin(input int ch, input logic v);
    din_pin[ch] <= v;
    // Synchroniser plus edge detection settle well inside this
    repeat (10) @(posedge aclk);
  endtask : pin

  task wait_irq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 50) begin
      @(posedge aclk);
      n++;
    end
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : wait_irq

  // Two rounds drain a process interrupt left pending behind the first
  task cleanup;
    repeat (2) begin
      w(12'h040, 32'h1, 2'h0);
      w(12'h044, 32'h3, 2'h0);
      repeat (10) @(posedge aclk);
    end
  endtask : cleanup

  // ==========================================================
  // Scenarios
  task t_outputs;
    r(12'h000, 2'h0);
    chk("out_reset", 32'h0, rv);
    w(12'h000, 32'h0000a5c3, 2'h0);
    chk("dout", 32'h0000a5c3, {16'h0, dout});
    u_cpu.wr(12'h000, 32'h00003c00, 4'h2, rs);
    chk("dout_byte1", 32'h00003cc3, {16'h0, dout});
    r(12'h000, 2'h0);
    chk("out_read", 32'h00003cc3, rv);
  endtask : t_outputs

  task t_errors;
    r(12'h100, 2'h2);
    chk("unmapped_data", 32'h0, rv);
    w(12'h008, 32'hffffffff, 2'h2);
  endtask : t_errors

  task t_process;
    w(12'h004, 32'h00000008, 2'h0);
    w(12'h048, 32'h1, 2'h0);
    pin(5, 1'h1);
    pin(3, 1'h1);
    wait_irq(1'h1);
    r(12'h034, 2'h0);
    chk("cause", 32'h00000008, rv);
    w(12'h048, 32'h0, 2'h0);
    wait_irq(1'h0);
    w(12'h048, 32'h1, 2'h0);
    wait_irq(1'h1);
    pin(3, 1'h0);
    w(12'h040, 32'h1, 2'h0);
    w(12'h044, 32'h1, 2'h0);
    repeat (20) @(posedge aclk);
    r(12'h044, 2'h0);
    chk("no_fall_irq", 32'h0, rv);
    wait_irq(1'h0);
  endtask : t_process

  task t_flags;
    w(12'h004, 32'h00080008, 2'h0);
    r(12'h008, 2'h0);
    r(12'h00c, 2'h0);
    din_pin[3] <= 1'h1;
    t0 = cyc;
    repeat (10) @(posedge aclk);
    r(12'h018, 2'h0);
    ts1 = rv[31:16];
    // Same phase against the microsecond ticker on both edges
    while (cyc < t0 + 400) @(posedge aclk);
    pin(3, 1'h0);
    r(12'h018, 2'h0);
    chk("ts_delta", 32'h14, {16'h0, rv[31:16] - ts1});
    r(12'h010, 2'h0);
    chk("lost", 32'h00000008, rv);
    r(12'h00c, 2'h0);
    chk("second", 32'h00000008, rv);
    ts1 = rv[15:0];
    r(12'h008, 2'h0);
    chk("first", 32'h00000008, rv);
    chk("consistent", 32'h0, {16'h0, u_cpu.consistent(rv[15:0], ts1)});
    r(12'h010, 2'h0);
    chk("lost_clear", 32'h0, rv);
    // Diagnostics disabled: the repeat edge is still held for reading
    r(12'h03c, 2'h0);
    chk("event_held", 32'h00000103, rv);
    r(12'h038, 2'h0);
    chk("record_held", 32'h40001f09, rv);
    cleanup();
  endtask : t_flags

  task t_diag;
    w(12'h1fc, 32'h1, 2'h0);
    w(12'h048, 32'h3, 2'h0);
    pin(3, 1'h1);
    pin(3, 1'h0);
    r(12'h044, 2'h0);
    chk("stat_in", 32'h3, rv);
    r(12'h03c, 2'h0);
    chk("event_in", 32'h00000103, rv);
    r(12'h038, 2'h0);
    chk("record", 32'h40001f09, rv);
    pin(3, 1'h1);
    aux_missing_pin <= 1'h1;
    w(12'h044, 32'h3, 2'h0);
    w(12'h040, 32'h2, 2'h0);
    w(12'h040, 32'h1, 2'h0);
    wait_irq(1'h1);
    r(12'h044, 2'h0);
    chk("stat_out", 32'h2, rv);
    r(12'h03c, 2'h0);
    chk("event_out", 32'h00000113, rv);
    r(12'h038, 2'h0);
    chk("record_out", 32'h00001f15, rv);
    w(12'h044, 32'h3, 2'h0);
    wait_irq(1'h0);
  endtask : t_diag

  task summarize;
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  // ==========================================================
  // Main sequence
  initial begin
    n_errors = 0;
    cmp_count = 0;
    aresetn = 1'h0;
    din_pin = 16'h0;
    aux_missing_pin = 1'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("irq_reset", 32'h0, {31'h0, irq});
    t_outputs();
    t_errors();
    t_process();
    t_flags();
    t_diag();
    summarize();
  end
endmodule : dio_edge_interrupt_diagnostics_bench
`default_nettype wire

//--- design/dei_cfg.svh
/*
  Address map, record fields and timing counts of the edge interrupt block.
  Assumes it is included by its bare name wherever the constants are used.
*/
`ifndef DEI_CFG_SVH
`define DEI_CFG_SVH
`define DEI_A_OUT 12'h000
`define DEI_A_EDGE 12'h004
`define DEI_A_FA1 12'h008
`define DEI_A_FA2 12'h00c
`define DEI_A_LOST 12'h010
`define DEI_A_TS 12'h014
`define DEI_A_TSEND 12'h030
`define DEI_A_CAUSE 12'h034
`define DEI_A_REC 12'h038
`define DEI_A_EVT 12'h03c
`define DEI_A_ACK 12'h040
`define DEI_A_STAT 12'h044
`define DEI_A_MASK 12'h048
`define DEI_A_DCFG 12'h1fc
`define DEI_CLK_NS 50
`define DEI_TICK_NS 1000
`define DEI_TICK_CYC (`DEI_TICK_NS / `DEI_CLK_NS)
`define DEI_CLASS_DIG 4'hf
`define DEI_RESP_OK 2'b00
`define DEI_RESP_ERR 2'b10
`endif

//--- design/dei_pkg.sv
/*
  Types of the edge interrupt block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dei_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_proc = 3'b010,
    st_diag = 3'b100
  } dei_state_t;
endpackage : dei_pkg

//--- design/dei_top.sv
/*
  Edge interrupt and diagnostic logic of a 16 in / 16 out I/O module,
  with an AXI4-Lite register slave.
  Assumes one 20 MHz clock, inputs asynchronous to it, one transfer per
  channel at a time on the bus.
*/
// The AXI4-Lite register port was decided locally.
//
// Contract
// - Timestamp is low 16 bits of us ticker
// - Repeat edge sets lost bit, latest stamp
// - Output bits drive channels, one is on
// - Process interrupt only on enabled polarity
// - Cause word flags edges, upper half zero
// - Diagnostic interrupt enable in config register
// - Repeat during service raises incoming diagnostic
// - Other events queue during diagnostic service
// - Queued diagnostics first, then process interrupts
// - Channel in diagnostic drops further events
// - Outgoing diagnostic after causing interrupt completes
// - Disabled diagnostic still holds last event
// - Record 0 latched as diagnostic interrupt data
// - Record byte 0 error bits, rest zero
// - Record byte 1 class and info, byte 2 zero
// - Record byte 3 bit 6 lost interrupt
`timescale 1ns/10ps
`default_nettype none
`include "dei_cfg.svh"
module dei_top import dei_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] din_pin,
  input wire logic aux_missing_pin,
  output logic [15:0] dout,
  output logic irq
);
  // ==========================================================
  // Functions
  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [3:0] lowest(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : lowest

  function automatic logic [31:0] rec_f(input logic d, input logic a);
    return {1'b0, d, 6'h00, 8'h00, 3'h0, 1'b1, `DEI_CLASS_DIG,
            3'h0, a, d, a, 1'b0, d | a};
  endfunction : rec_f

  // ==========================================================
  // Input synchronisers and edge detection
  logic [15:0] s1_r, s2_r, s3_r, lvl_r;
  logic a1_r, a2_r, a3_r, aux_r;
  logic [15:0] edge_v;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 16'h0000;
      s2_r <= 16'h0000;
      s3_r <= 16'h0000;
      lvl_r <= 16'h0000;
      a1_r <= 1'b0;
      a2_r <= 1'b0;
      a3_r <= 1'b0;
      aux_r <= 1'b0;
    end else begin
      s1_r <= din_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);
      a1_r <= aux_missing_pin;
      a2_r <= a1_r;
      a3_r <= a2_r;
      aux_r <= (a2_r == a3_r) ? a3_r : aux_r;
    end
  end
  // A change counts only once the last two stages agree
  assign edge_v = ~(s2_r ^ s3_r) & (s3_r ^ lvl_r);

  // ==========================================================
  // Microsecond ticker
  logic [4:0] pre_r;
  logic [15:0] us_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r <= 5'h00;
      us_r <= 16'h0000;
    end else if (pre_r == 5'(`DEI_TICK_CYC - 1)) begin
      pre_r <= 5'h00;
      us_r <= us_r + 16'h0001;
    end else begin
      pre_r <= pre_r + 5'h01;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  logic aw_h_r, w_h_r, bv_r, rv_r;
  logic [11:0] wa_r;
  logic [31:0] wd_r, rd_v, rd_r;
  logic [3:0] ws_r;
  logic [1:0] br_r, rr_r;
  logic do_wr, rd_go, rd_ok;
  assign s_axi_awready = !aw_h_r;
  assign s_axi_wready = !w_h_r;
  assign s_axi_arready = !rv_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = br_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rresp = rr_r;
  assign s_axi_rdata = rd_r;
  assign do_wr = aw_h_r && w_h_r && !bv_r;
  assign rd_go = s_axi_arvalid && !rv_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      bv_r <= 1'b0;
      br_r <= `DEI_RESP_OK;
      wa_r <= 12'h000;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_h_r) begin
        aw_h_r <= 1'b1;
        wa_r <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_h_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_h_r) begin
        w_h_r <= 1'b1;
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
      end else if (do_wr) begin
        w_h_r <= 1'b0;
      end
      if (do_wr) begin
        bv_r <= 1'b1;
        br_r <= (wa_r == `DEI_A_OUT || wa_r == `DEI_A_EDGE ||
                 wa_r == `DEI_A_ACK || wa_r == `DEI_A_STAT ||
                 wa_r == `DEI_A_MASK || wa_r == `DEI_A_DCFG) ?
                `DEI_RESP_OK : `DEI_RESP_ERR;
      end else if (s_axi_bready) begin
        bv_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Registers written by software
  logic [15:0] out_r;
  logic [31:0] out_m;
  logic [31:0] en_r;
  logic dcfg_r;
  logic [1:0] mask_r, stat_r, iss;
  logic pi_ack, dg_ack;
  dei_state_t st_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= 16'h0000;
      en_r <= 32'h0;
      dcfg_r <= 1'b0;
      mask_r <= 2'h0;
    end else if (do_wr) begin
      if (wa_r == `DEI_A_OUT) begin
        out_r <= out_m[15:0];
      end else if (wa_r == `DEI_A_EDGE) begin
        en_r <= merge(en_r, wd_r, ws_r);
      end else if (wa_r == `DEI_A_DCFG && ws_r[0]) begin
        dcfg_r <= wd_r[0];
      end else if (wa_r == `DEI_A_MASK && ws_r[0]) begin
        mask_r <= wd_r[1:0];
      end
    end
  end
  assign dout = out_r;
  // A function result cannot be sliced directly, so merge into a word
  assign out_m = merge({16'h0, out_r}, wd_r, ws_r);
  assign pi_ack = do_wr && wa_r == `DEI_A_ACK && ws_r[0] && wd_r[0] &&
                  st_r == st_proc;
  assign dg_ack = do_wr && wa_r == `DEI_A_ACK && ws_r[0] && wd_r[1] &&
                  st_r == st_diag;
  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= 2'h0;
    end else if (do_wr && wa_r == `DEI_A_STAT && ws_r[0]) begin
      stat_r <= (stat_r & ~wd_r[1:0]) | iss;
    end else begin
      stat_r <= stat_r | iss;
    end
  end
  assign irq = |(stat_r & mask_r);

  // ==========================================================
  // Edge flags and timestamps
  logic [15:0] fa1_r, fa2_r, fv_r;
  logic [15:0] ts_r [16];
  logic rd_fa1, rd_fa2;
  assign rd_fa1 = rd_go && s_axi_araddr == `DEI_A_FA1;
  assign rd_fa2 = rd_go && s_axi_araddr == `DEI_A_FA2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fa1_r <= 16'h0000;
      fa2_r <= 16'h0000;
      fv_r <= 16'h0000;
    end else begin
      fa1_r <= (fa1_r & ~{16{rd_fa1}}) | edge_v;
      fv_r <= (fv_r & ~{16{rd_fa1}}) | (edge_v & fa1_r);
      fa2_r <= (fa2_r & ~{16{rd_fa2}}) | (edge_v & fa1_r);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 16; i++) begin
        ts_r[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (edge_v[i]) begin
          ts_r[i] <= us_r;
        end
      end
    end
  end

  // ==========================================================
  // Event qualification and diagnostic queue
  logic [15:0] ev, lost, lost_d, pend_r, cause_r, dact_r, inc_r, due_r;
  logic [3:0] fifo_r [16];
  logic [3:0] wp_r, rp_r, och;
  logic [4:0] cnt_r;
  logic pi_act_r, push, pop_in, pop_out, iss_pi;
  logic [15:0] och_m;
  assign ev = edge_v & ((en_r[15:0] & s3_r) | (en_r[31:16] & ~s3_r)) &
              ~dact_r;
  assign lost = ev & cause_r & {16{pi_act_r}};
  assign lost_d = lost & {16{dcfg_r}};
  assign push = |inc_r;
  assign pop_in = cnt_r != 5'h00 &&
                  (st_r == st_idle || (st_r == st_proc && !pi_ack));
  assign pop_out = st_r == st_idle && cnt_r == 5'h00 && !push &&
                   |due_r;
  assign iss_pi = st_r == st_idle && cnt_r == 5'h00 && !push &&
                  due_r == 16'h0000 && |pend_r;
  assign iss = {pop_in | pop_out, iss_pi};
  assign och = lowest(due_r);
  assign och_m = 16'h0001 << och;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= 16'h0000;
      inc_r <= 16'h0000;
      dact_r <= 16'h0000;
      due_r <= 16'h0000;
    end else begin
      // A new event beats the take of the pending set
      pend_r <= (pend_r & ~(iss_pi ? pend_r : 16'h0000)) |
                (ev & ~lost_d);
      inc_r <= (inc_r & ~(push ? 16'h0001 << lowest(inc_r) : 16'h0)) |
               lost_d;
      dact_r <= (dact_r & ~(pop_out ? och_m : 16'h0000)) | lost_d;
      due_r <= (due_r & ~(pop_out ? och_m : 16'h0000)) |
               (pi_ack ? cause_r & (dact_r | lost_d) : 16'h0000);
    end
  end
  // One entry per diagnosed channel, so sixteen entries never overflow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_r <= 4'h0;
      rp_r <= 4'h0;
      cnt_r <= 5'h00;
      for (int i = 0; i < 16; i++) begin
        fifo_r[i] <= 4'h0;
      end
    end else begin
      if (push) begin
        fifo_r[wp_r] <= lowest(inc_r);
        wp_r <= wp_r + 4'h1;
      end
      if (pop_in) begin
        rp_r <= rp_r + 4'h1;
      end
      cnt_r <= cnt_r + {4'h0, push} - {4'h0, pop_in};
    end
  end

  // ==========================================================
  // Service state machine and diagnostic record
  logic [31:0] rec_r;
  logic [8:0] evt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= st_idle;
      pi_act_r <= 1'b0;
      cause_r <= 16'h0000;
      rec_r <= 32'h0;
      evt_r <= 9'h000;
    end else begin
      case (st_r)
        st_idle: begin
          if (pop_in || pop_out) begin
            st_r <= st_diag;
          end else if (iss_pi) begin
            st_r <= st_proc;
            pi_act_r <= 1'b1;
            cause_r <= pend_r;
          end
        end
        st_proc: begin
          if (pi_ack) begin
            st_r <= st_idle;
            pi_act_r <= 1'b0;
          end else if (pop_in) begin
            st_r <= st_diag;
          end
        end
        st_diag: begin
          if (dg_ack) begin
            st_r <= pi_act_r ? st_proc : st_idle;
          end
        end
        default: begin
          st_r <= st_idle;
        end
      endcase
      if (pop_in) begin
        rec_r <= rec_f(1'b1, aux_r);
        evt_r <= {1'b1, 3'h0, 1'b0, fifo_r[rp_r]};
      end else if (pop_out) begin
        rec_r <= rec_f(|(dact_r & ~och_m), aux_r);
        evt_r <= {1'b1, 3'h0, 1'b1, och};
      end else if (|(lost & ~lost_d)) begin
        rec_r <= rec_f(1'b1, aux_r);
        evt_r <= {1'b1, 3'h0, 1'b0, lowest(lost)};
      end
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    rd_v = 32'h0;
    rd_ok = 1'b1;
    if (s_axi_araddr == `DEI_A_OUT) begin
      rd_v = {16'h0, out_r};
    end else if (s_axi_araddr == `DEI_A_EDGE) begin
      rd_v = en_r;
    end else if (s_axi_araddr == `DEI_A_FA1) begin
      rd_v = {16'h0, fa1_r};
    end else if (s_axi_araddr == `DEI_A_FA2) begin
      rd_v = {16'h0, fa2_r};
    end else if (s_axi_araddr == `DEI_A_LOST) begin
      rd_v = {16'h0, fv_r};
    end else if (s_axi_araddr >= `DEI_A_TS &&
                 s_axi_araddr <= `DEI_A_TSEND &&
                 s_axi_araddr[1:0] == 2'h0) begin
      rd_v = {ts_r[{s_axi_araddr[4:2] - 3'h5, 1'b1}],
              ts_r[{s_axi_araddr[4:2] - 3'h5, 1'b0}]};
    end else if (s_axi_araddr == `DEI_A_CAUSE) begin
      rd_v = {16'h0, cause_r};
    end else if (s_axi_araddr == `DEI_A_REC) begin
      rd_v = rec_r;
    end else if (s_axi_araddr == `DEI_A_EVT) begin
      rd_v = {23'h0, evt_r};
    end else if (s_axi_araddr == `DEI_A_STAT) begin
      rd_v = {30'h0, stat_r};
    end else if (s_axi_araddr == `DEI_A_MASK) begin
      rd_v = {30'h0, mask_r};
    end else if (s_axi_araddr == `DEI_A_DCFG) begin
      rd_v = {31'h0, dcfg_r};
    end else begin
      rd_ok = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv_r <= 1'b0;
      rd_r <= 32'h0;
      rr_r <= `DEI_RESP_OK;
    end else if (rd_go) begin
      rv_r <= 1'b1;
      rd_r <= rd_v;
      rr_r <= rd_ok ? `DEI_RESP_OK : `DEI_RESP_ERR;
    end else if (s_axi_rready) begin
      rv_r <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_ts_latest: assert property (edge_v[3] |=>
    ts_r[3] == $past(us_r)) else $error("stamp not latest");
  chk_lost_set: assert property (edge_v[3] && fa1_r[3] &&
    !rd_fa1 |=> fv_r[3] && fa2_r[3]) else $error("lost not set");
  chk_out_drive: assert property (do_wr && wa_r == `DEI_A_OUT &&
    ws_r == 4'hf |=> dout == $past(wd_r[15:0]))
    else $error("output not driven");
  chk_edge_gate: assert property (edge_v[5] && !en_r[5] &&
    !en_r[21] |=> !(pend_r[5] && !$past(pend_r[5])))
    else $error("unenabled edge pended");
  chk_lost_diag: assert property (lost_d[3] |=> dact_r[3] ##1
    cnt_r != 5'h00 || st_r == st_diag) else $error("no incoming");
  chk_drop_event: assert property (dact_r[3] && !pend_r[3] |=>
    !pend_r[3]) else $error("event kept");
  chk_diag_first: assert property (st_r == st_idle &&
    cnt_r != 5'h00 |=> st_r == st_diag && stat_r[1])
    else $error("diag not first");
  chk_pi_issue: assert property (iss_pi |=> st_r == st_proc &&
    cause_r != 16'h0000 && stat_r[0]) else $error("pi not issued");
  chk_rec_lost: assert property (pop_in |=> rec_r[30] &&
    rec_r[3] && rec_r[11:8] == `DEI_CLASS_DIG)
    else $error("record wrong");
endmodule : dei_top
`default_nettype wire
